// *** rtl/bram_consts.svh ***
// Constants for the two-port embedded block memory with its register slave.
// Assumes inclusion by bare name from the package and from the memory module.
`ifndef BRAM_CONSTS_SVH
`define BRAM_CONSTS_SVH

`define MEM_DATA_W      36
`define MEM_ADDR_W      9
`define APB_ADDR_W      12

`define CFG_OFS         12'h000
`define STATUS_OFS      12'h004
`define CFG_RST         32'h0000_0000
`define STATUS_RST      2'h0

`define CFG_A_MODE_LSB  0
`define CFG_B_MODE_LSB  2
`define CFG_A_OREG      4
`define CFG_B_OREG      5
`define CFG_A_ASYNC     6
`define CFG_B_ASYNC     7

`define STATUS_A_REJ    0
`define STATUS_B_REJ    1

`endif

// *** rtl/bram_pkg.sv ***
// Types shared by the block memory and whatever instantiates it.
// Assumes the constants header is on the include path.
`include "bram_consts.svh"

package bram_pkg;

    typedef enum logic [1:0] {WM_NORMAL, WM_THROUGH, WM_RBW, WM_RSVD} write_mode_type;

    typedef struct packed {
        logic                   en;
        logic                   we;
        logic [`MEM_ADDR_W-1:0] addr;
        logic [`MEM_DATA_W-1:0] wdata;
    } port_req_type;

    typedef struct packed {
        write_mode_type mode;
        logic           oreg;
        logic           async_rst;
    } port_cfg_type;

    typedef struct packed {
        port_req_type           q;
        logic [`MEM_DATA_W-1:0] lat;
        logic [`MEM_DATA_W-1:0] dout;
    } port_state_type;

    typedef struct packed {
        port_state_type         a;
        port_state_type         b;
        port_cfg_type           cfg_a;
        port_cfg_type           cfg_b;
        logic [1:0]             reject;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } block_state_type;

endpackage

// *** rtl/block_ram.sv ***
// Two-port embedded block memory with per-port write behaviour, optional
// output register and output latch resets; configured over APB.
// Assumes both ports and the bus share one clock and inputs are synchronous.
`timescale 1ns/1ps
`include "bram_consts.svh"

// Operation
// - Each port's address and write data are registered before reaching the array.
// - A configuration bit per port adds a register on the read data output.
// - Normal mode shows array data only on reads; writes leave output unchanged.
// - Write-through mode drives the port output with the data being written.
// - Read-before-write shows old contents on a write; only 9, 18, 36 bit widths.
// - Output latches clear on the next clock edge, with or without an enabled cycle as configured per port.
// - Each local output reset clears only its own port's output latches.
// - The active-low global reset clears both ports' output latches.
module block_ram #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 9
) (
    input  wire logic                      clock,               // System clock
    input  wire logic                      rst_b,               // Async reset, active low
    input  wire logic                      psel,                // APB select
    input  wire logic                      penable,             // APB enable
    input  wire logic                      pwrite,              // APB direction
    input  wire logic [`APB_ADDR_W-1:0]    paddr,               // APB byte address
    input  wire logic [31:0]               pwdata,              // APB write data
    output logic                           pready,              // APB ready
    output logic                           pslverr,             // APB error
    output logic [31:0]                    prdata,              // APB read data
    input  wire bram_pkg::port_req_type    a_req,               // Port A request
    input  wire bram_pkg::port_req_type    b_req,               // Port B request
    input  wire logic                      port_a_output_reset, // Port A latch clear
    input  wire logic                      port_b_output_reset, // Port B latch clear
    input  wire logic                      global_reset_low,    // Both ports, active low
    output logic [`MEM_DATA_W-1:0]         a_rdata,             // Port A read data
    output logic [`MEM_DATA_W-1:0]         b_rdata              // Port B read data
);
    import bram_pkg::*;

    //------------------------------------------------------------
    // Elaboration checks
    //------------------------------------------------------------
    if (DATA_W < 1 || DATA_W > `MEM_DATA_W) begin : g_bad_data_w
        $error("DATA_W out of range");
    end
    if (ADDR_W < 1 || ADDR_W > `MEM_ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    localparam logic RBW_OK = (DATA_W == 9) || (DATA_W == 18) || (DATA_W == 36);
    localparam logic [`MEM_DATA_W-1:0] DMASK = {`MEM_DATA_W{1'b1}} >> (`MEM_DATA_W - DATA_W);
    localparam logic [`MEM_ADDR_W-1:0] AMASK = {`MEM_ADDR_W{1'b1}} >> (`MEM_ADDR_W - ADDR_W);

    //------------------------------------------------------------
    // Reset release
    //------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    //------------------------------------------------------------
    // State and array
    //------------------------------------------------------------
    block_state_type         st_ff;
    block_state_type         nxt_st;
    logic [`MEM_DATA_W-1:0]  mem [0:(1 << ADDR_W)-1];
    logic [`MEM_DATA_W-1:0]  rd_a;
    logic [`MEM_DATA_W-1:0]  rd_b;
    logic                    a_wr;
    logic                    b_wr;

    // Array reads see the registered address, before this edge's write
    assign rd_a = mem[st_ff.a.q.addr[ADDR_W-1:0]];
    assign rd_b = mem[st_ff.b.q.addr[ADDR_W-1:0]];
    assign a_wr = st_ff.a.q.en && st_ff.a.q.we;
    assign b_wr = st_ff.b.q.en && st_ff.b.q.we;

    // Same-address collision: port A lands last and wins
    always_ff @(posedge clock) begin
        if (b_wr) begin
            mem[st_ff.b.q.addr[ADDR_W-1:0]] <= st_ff.b.q.wdata;
        end
        if (a_wr) begin
            mem[st_ff.a.q.addr[ADDR_W-1:0]] <= st_ff.a.q.wdata;
        end
    end

    //------------------------------------------------------------
    // Functions
    //------------------------------------------------------------
    function automatic port_cfg_type mk_cfg(input logic [1:0] m,
                                            input logic       oreg,
                                            input logic       asy);
        port_cfg_type c;
        c.mode      = write_mode_type'(m);
        c.oreg      = oreg;
        c.async_rst = asy;
        // Read-before-write refused at unsupported widths
        if (c.mode == WM_RSVD || (c.mode == WM_RBW && !RBW_OK)) begin
            c.mode = WM_NORMAL;
        end
        return c;
    endfunction

    function automatic logic is_reject(input logic [1:0] m);
        return (m == 2'h3) || (m == 2'h2 && !RBW_OK);
    endfunction

    function automatic port_state_type port_step(input port_state_type         s,
                                                 input port_req_type           req,
                                                 input port_cfg_type           c,
                                                 input logic [`MEM_DATA_W-1:0] rd,
                                                 input logic                   lrst,
                                                 input logic                   grst_b);
        port_state_type n;
        logic           clr;
        n = s;
        // Input capture ahead of the array
        n.q       = req;
        n.q.addr  = req.addr & AMASK;
        n.q.wdata = req.wdata & DMASK;
        if (s.q.en) begin
            if (!s.q.we) begin
                n.lat = rd;
            end else begin
                case (c.mode)
                    WM_NORMAL:  n.lat = s.lat;
                    WM_THROUGH: n.lat = s.q.wdata;
                    WM_RBW:     n.lat = rd;
                    default:    n.lat = s.lat;
                endcase
            end
        end
        // Output register or straight through from the latch
        n.dout = c.oreg ? s.lat : n.lat;
        // Async style clears regardless of enable; sync only on an enabled cycle
        clr = !grst_b || (lrst && (c.async_rst || s.q.en));
        if (clr) begin
            n.lat  = '0;
            n.dout = '0;
        end
        return n;
    endfunction

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        logic setup;
        logic access;
        logic cfg_hit;
        logic sts_hit;
        logic [1:0] new_rej;
        logic [1:0] clr_rej;
        setup   = psel && !penable;
        access  = psel && penable && st_ff.pready;
        cfg_hit = paddr == `CFG_OFS;
        sts_hit = paddr == `STATUS_OFS;
        new_rej = 2'h0;
        clr_rej = 2'h0;
        nxt_st  = st_ff;

        // Each port sees only its own local reset
        nxt_st.a = port_step(st_ff.a, a_req, st_ff.cfg_a, rd_a,
                             port_a_output_reset, global_reset_low);
        nxt_st.b = port_step(st_ff.b, b_req, st_ff.cfg_b, rd_b,
                             port_b_output_reset, global_reset_low);

        // Bus slave: answer in the first access cycle
        nxt_st.pready = setup;
        if (setup) begin
            nxt_st.pslverr = !(cfg_hit || sts_hit);
            nxt_st.prdata  = 32'h0000_0000;
            if (cfg_hit) begin
                nxt_st.prdata[`CFG_A_MODE_LSB +: 2] = st_ff.cfg_a.mode;
                nxt_st.prdata[`CFG_B_MODE_LSB +: 2] = st_ff.cfg_b.mode;
                nxt_st.prdata[`CFG_A_OREG]          = st_ff.cfg_a.oreg;
                nxt_st.prdata[`CFG_B_OREG]          = st_ff.cfg_b.oreg;
                nxt_st.prdata[`CFG_A_ASYNC]         = st_ff.cfg_a.async_rst;
                nxt_st.prdata[`CFG_B_ASYNC]         = st_ff.cfg_b.async_rst;
            end else if (sts_hit) begin
                nxt_st.prdata[1:0] = st_ff.reject;
            end
        end
        if (access && pwrite && cfg_hit) begin
            nxt_st.cfg_a = mk_cfg(pwdata[`CFG_A_MODE_LSB +: 2], pwdata[`CFG_A_OREG],
                                  pwdata[`CFG_A_ASYNC]);
            nxt_st.cfg_b = mk_cfg(pwdata[`CFG_B_MODE_LSB +: 2], pwdata[`CFG_B_OREG],
                                  pwdata[`CFG_B_ASYNC]);
            new_rej[`STATUS_A_REJ] = is_reject(pwdata[`CFG_A_MODE_LSB +: 2]);
            new_rej[`STATUS_B_REJ] = is_reject(pwdata[`CFG_B_MODE_LSB +: 2]);
        end
        if (access && pwrite && sts_hit) begin
            clr_rej = pwdata[1:0];
        end
        // Set wins over write-one-to-clear
        nxt_st.reject = (st_ff.reject & ~clr_rej) | new_rej;
    end

    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pready  = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign prdata  = st_ff.prdata;
    assign a_rdata = st_ff.a.dout;
    assign b_rdata = st_ff.b.dout;

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_ff);

    sequence s_a_write;
        a_req.en && a_req.we ##1 (a_wr && !(b_wr && st_ff.b.q.addr == st_ff.a.q.addr));
    endsequence

    property p_input_capture;
        s_a_write |=> mem[$past(st_ff.a.q.addr[ADDR_W-1:0])] == $past(st_ff.a.q.wdata);
    endproperty
    a_input_capture: assert property (p_input_capture)
        else $error("port A write did not reach the array");

    property p_oreg_on;
        st_ff.cfg_a.oreg && global_reset_low && !port_a_output_reset
            |=> a_rdata == $past(st_ff.a.lat);
    endproperty
    a_oreg_on: assert property (p_oreg_on)
        else $error("registered output did not lag the latch");

    property p_oreg_off;
        !st_ff.cfg_a.oreg && global_reset_low && !port_a_output_reset
            |=> a_rdata == st_ff.a.lat;
    endproperty
    a_oreg_off: assert property (p_oreg_off)
        else $error("unregistered output differs from latch");

    property p_normal_write;
        a_wr && st_ff.cfg_a.mode == WM_NORMAL && global_reset_low && !port_a_output_reset
            |=> st_ff.a.lat == $past(st_ff.a.lat);
    endproperty
    a_normal_write: assert property (p_normal_write)
        else $error("normal mode write changed the output");

    property p_write_through;
        a_wr && st_ff.cfg_a.mode == WM_THROUGH && global_reset_low && !port_a_output_reset
            |=> st_ff.a.lat == $past(st_ff.a.q.wdata);
    endproperty
    a_write_through: assert property (p_write_through)
        else $error("write-through did not show write data");

    property p_read_before_write;
        a_wr && st_ff.cfg_a.mode == WM_RBW && global_reset_low && !port_a_output_reset
            |=> st_ff.a.lat == $past(rd_a);
    endproperty
    a_read_before_write: assert property (p_read_before_write)
        else $error("read-before-write did not show old contents");

    property p_async_clear;
        port_a_output_reset && st_ff.cfg_a.async_rst |=> st_ff.a.lat == '0 && a_rdata == '0;
    endproperty
    a_async_clear: assert property (p_async_clear)
        else $error("async style reset did not clear port A");

    property p_sync_hold;
        port_a_output_reset && !st_ff.cfg_a.async_rst && !st_ff.a.q.en && global_reset_low
            |=> st_ff.a.lat == $past(st_ff.a.lat);
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("sync style reset acted without an enabled cycle");

    property p_local_only;
        port_a_output_reset && !port_b_output_reset && global_reset_low && !st_ff.b.q.en
            |=> st_ff.b.lat == $past(st_ff.b.lat);
    endproperty
    a_local_only: assert property (p_local_only)
        else $error("port A reset disturbed port B");

    property p_global_clear;
        !global_reset_low |=> st_ff.a.lat == '0 && st_ff.b.lat == '0
                              && a_rdata == '0 && b_rdata == '0;
    endproperty
    a_global_clear: assert property (p_global_clear)
        else $error("global reset did not clear both ports");

endmodule

// *** verif/fabric_port.sv ***
// Fabric-side model that drives one memory port request.
// Assumes its task is entered right after a rising clock edge.
`timescale 1ns/1ps

module fabric_port (
    input  wire logic              clock, // System clock
    output bram_pkg::port_req_type req    // Request to one port
);
    import bram_pkg::*;

    initial req = '0;

    // ----------------------------------------
    // One access, then release with scrambled lines
    // ----------------------------------------
    task automatic access(input logic we, input logic [8:0] ad, input logic [35:0] wd,
                          input int extra);
        req <= '{en: 1'b1, we: we, addr: ad, wdata: wd};
        @(posedge clock);
        req <= '{en: 1'b0, we: 1'b0, addr: ~ad, wdata: ~wd};
        repeat (1 + extra) @(posedge clock);
        #1;
    endtask
endmodule

// *** verif/block_ram_bench.sv ***
// Self-checking bench for the two-port block memory and its APB slave.
// Assumes the APB slave answers before the timeout and one-request port latencies.
`timescale 1ns/1ps

module block_ram_bench;
    import bram_pkg::*;

    logic                   clock = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]            paddr = '0;
    logic [31:0]            pwdata = '0, prdata;
    logic                   pready, pslverr;
    logic                   lrst_a = 1'b0, lrst_b = 1'b0, grst_b = 1'b1;
    port_req_type           a_req, b_req;
    logic [35:0]            a_rdata, b_rdata;
    int                     errors = 0, n_tests = 0;

    always #12.5 clock = ~clock;

    fabric_port pa (.clock(clock), .req(a_req));
    fabric_port pb (.clock(clock), .req(b_req));

    block_ram DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .a_req(a_req), .b_req(b_req),
        .port_a_output_reset(lrst_a), .port_b_output_reset(lrst_b),
        .global_reset_low(grst_b), .a_rdata(a_rdata), .b_rdata(b_rdata));

    // ----------------------------------------
    // Report and compare
    // ----------------------------------------
    task automatic test_done;
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk_dat(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: port data %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: err+register %h, wanted %h", $time, got, exp);
        end
    endtask

    // ----------------------------------------
    // APB master and port helpers
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                       input logic [32:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("unexpected at %0t: no pready", $time);
            test_done();
        end else if (!wr) begin
            chk_reg({pslverr, prdata}, exp);
        end
    endtask

    task automatic port(input bit b, input logic we, input logic [8:0] ad,
                        input logic [35:0] wd, input int extra);
        @(posedge clock);
        if (b) pb.access(we, ad, wd, extra);
        else pa.access(we, ad, wd, extra);
    endtask

    task automatic pulse(input int which);
        @(posedge clock);
        if (which == 0) lrst_a <= 1'b1;
        else if (which == 1) grst_b <= 1'b0;
        else lrst_b <= 1'b1;
        @(posedge clock);
        lrst_a <= 1'b0;
        lrst_b <= 1'b0;
        grst_b <= 1'b1;
        @(posedge clock);
        #1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        apb(0, 12'h000, '0, 33'h0);
        apb(0, 12'h004, '0, 33'h0);
        apb(0, 12'h008, '0, 33'h1_0000_0000);
        $display("test registers done");
        port(0, 1, 9'h003, 36'h123456789, 0);
        port(0, 0, 9'h003, '0, 0);
        chk_dat(a_rdata, 36'h123456789);
        port(1, 0, 9'h003, '0, 0);
        chk_dat(b_rdata, 36'h123456789);
        port(0, 1, 9'h003, 36'hfedcba987, 0);
        chk_dat(a_rdata, 36'h123456789);
        $display("test normal done");
        apb(1, 12'h000, 32'h0000_0001, '0);
        port(0, 1, 9'h004, 36'ha5a5a5a5a, 0);
        chk_dat(a_rdata, 36'ha5a5a5a5a);
        apb(1, 12'h000, 32'h0000_0002, '0);
        port(0, 1, 9'h003, 36'h111111111, 0);
        chk_dat(a_rdata, 36'hfedcba987);
        port(1, 0, 9'h003, '0, 0);
        chk_dat(b_rdata, 36'h111111111);
        $display("test write modes done");
        apb(1, 12'h000, 32'h0000_000f, '0);
        apb(0, 12'h000, '0, 33'h0);
        apb(0, 12'h004, '0, 33'h3);
        apb(1, 12'h004, 32'h0000_0003, '0);
        apb(0, 12'h004, '0, 33'h0);
        $display("test reserved mode done");
        apb(1, 12'h000, 32'h0000_0010, '0);
        port(0, 0, 9'h004, '0, 0);
        chk_dat(a_rdata, 36'hfedcba987);
        @(posedge clock);
        #1;
        chk_dat(a_rdata, 36'ha5a5a5a5a);
        $display("test output register done");
        apb(1, 12'h000, 32'h0000_0000, '0);
        pulse(0);
        chk_dat(a_rdata, 36'ha5a5a5a5a);
        @(posedge clock);
        lrst_a <= 1'b1;
        pa.access(0, 9'h003, '0, 0);
        chk_dat(a_rdata, 36'h0);
        chk_dat(b_rdata, 36'h111111111);
        @(posedge clock);
        lrst_a <= 1'b0;
        apb(1, 12'h000, 32'h0000_0040, '0);
        port(0, 0, 9'h004, '0, 0);
        pulse(0);
        chk_dat(a_rdata, 36'h0);
        chk_dat(b_rdata, 36'h111111111);
        $display("test local reset done");
        port(0, 0, 9'h004, '0, 0);
        pulse(1);
        chk_dat(a_rdata, 36'h0);
        chk_dat(b_rdata, 36'h0);
        $display("test global reset done");
        apb(1, 12'h000, 32'h0000_0080, '0);
        port(1, 0, 9'h003, '0, 0);
        port(0, 0, 9'h004, '0, 0);
        pulse(2);
        chk_dat(b_rdata, 36'h0);
        chk_dat(a_rdata, 36'ha5a5a5a5a);
        $display("test port B reset done");
        test_done();
    end
endmodule
